// ### include/tas_consts.svh
// constants for the teach attribute and status indicator block
`ifndef TAS_CONSTS_SVH
`define TAS_CONSTS_SVH
// attribute path of the teach byte
`define TAS_CLASS 16'h0096
`define TAS_INST 16'h0001
`define TAS_ATTR 8'h08
// teach byte field positions
`define TAS_BIT_CMD 0
`define TAS_BIT_DONE 0
`define TAS_BIT_FAIL 1
// reset values: idle counts as completed, no defect
`define TAS_DONE_RST 1'b1
`define TAS_FAIL_RST 1'b0
// timing
`define TAS_CLK_KHZ 125000
`define TAS_STEP_MS 250
`define TAS_FLASH_MS 500
`endif

// ### include/tas_pkg.sv
// types for the teach attribute and status indicator block
package tas_pkg;
  typedef struct packed {
    logic write;
    logic [15:0] cls;
    logic [15:0] inst;
    logic [7:0] attr;
    logic [7:0] data;
  } tas_req_t;

  typedef struct packed {
    logic grn;
    logic red;
  } tas_led_t;

  typedef enum logic [2:0] {
    LT_GREEN,
    LT_RED,
    LT_OFF,
    LT_BOTH,
    LT_RUN
  } tas_lamp_t;
endpackage

// ### sim/tas_master_model.sv
// master model issuing explicit get and set requests to the teach byte
`timescale 1ns/10ps
module tas_master_model
  import tas_pkg::*;
(
  // clock
  input wire logic clk_i,
  // request side
  output logic req_valid_o,
  output tas_req_t req_o,
  // answer side
  input wire logic rsp_valid_i,
  input wire logic [7:0] rsp_data_i,
  input wire logic rsp_err_i
);
  // instance number sent with every request, changed by the bench for path tests
  logic [15:0] inst_sel = 16'h0001;

  initial begin
    req_valid_o = 1'h0;
    req_o = '0;
  end

  // set or get on a class/attribute path
  task automatic access(input logic wr, input logic [15:0] c, input logic [7:0] at,
                        input logic [7:0] d, output logic [7:0] q, output logic e);
    @(posedge clk_i);
    #1;
    req_o.write = wr;
    req_o.cls = c;
    req_o.inst = inst_sel;
    req_o.attr = at;
    // upper bits zero, bit 1 never commanded
    req_o.data = wr ? {7'h00, d[0]} : 8'h00;
    req_valid_o = 1'h1;
    @(posedge clk_i);
    #1;
    req_valid_o = 1'h0;
    // released lines show no stale request
    req_o = ~req_o;
    // answer must stand right after the taking edge
    q = (rsp_valid_i === 1'h1) ? rsp_data_i : 8'hXX;
    e = rsp_err_i;
  endtask
endmodule // tas_master_model

// ### sim/tas_teach_leds_test.sv
// bench for the teach attribute and status indicators
`timescale 1ns/10ps
module tas_teach_leds_test import tas_pkg::*;;
  logic clk_i = 1'h0;
  logic rstn_i = 1'h0;
  logic req_valid_i;
  tas_req_t req_i;
  logic rsp_valid_o;
  logic rsp_err_o;
  logic teach_start_o;
  logic [7:0] rsp_data_o;
  logic teach_end_i = 1'h0;
  logic teach_fail_i = 1'h0;
  logic dup_done_i = 1'h1;
  logic online_i = 1'h1;
  logic connected_i = 1'h1;
  logic io_timeout_i = 1'h0;
  logic crit_fault_i = 1'h0;
  tas_led_t bus_led_o;
  tas_led_t dev_led_o;
  tas_led_t a;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  // green, red, off, both, then run with bus green
  logic [1:0] lamp [5] = '{2'h2, 2'h1, 2'h0, 2'h3, 2'h2};
  // crit, dup, timeout, online, connected, flashing, colour
  logic [7:0] tbl [6] = '{8'h18, 8'h81, 8'h7D, 8'h5A, 8'h56, 8'h40};

  always #4 clk_i = ~clk_i;

  tas_teach_leds #(.STEP_CYC(8), .FLASH_CYC(4)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_err_o(rsp_err_o),
    .teach_start_o(teach_start_o), .teach_end_i(teach_end_i), .teach_fail_i(teach_fail_i),
    .dup_done_i(dup_done_i), .online_i(online_i), .connected_i(connected_i),
    .io_timeout_i(io_timeout_i), .crit_fault_i(crit_fault_i),
    .bus_led_o(bus_led_o), .dev_led_o(dev_led_o));

  tas_master_model m (
    .clk_i(clk_i), .req_valid_o(req_valid_i), .req_o(req_i),
    .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o), .rsp_err_i(rsp_err_o));

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic acc(input logic wr, input logic [15:0] c, input logic [7:0] at,
                     input logic [7:0] d, input logic [7:0] eq, input logic ee, input logic es);
    logic [7:0] q;
    logic e;
    m.access(wr, c, at, d, q, e);
    chk("rsp_data", eq, q);
    chk("rsp_err", {7'h00, ee}, {7'h00, e});
    chk("teach_start", {7'h00, es}, {7'h00, teach_start_o});
  endtask

  task automatic fin(input logic f);
    teach_end_i = 1'h1;
    teach_fail_i = f;
    step(1);
    teach_end_i = 1'h0;
  endtask

  task automatic end_of_test;
    $display("comparisons %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard, run needs just over a hundred cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    repeat (2) @(posedge clk_i);
    #1;
    rstn_i = 1'h1;
    step(2);
    // status inputs already asserted, lamp test must mask them
    for (int k = 0; k < 5; k++) begin
      chk("bus_lamp", {6'h00, lamp[k]}, {6'h00, bus_led_o});
      chk("dev_lamp", {6'h00, k == 4 ? 2'h2 : lamp[k]}, {6'h00, dev_led_o});
      step(8);
    end
    // samples one half period apart separate steady from flashing
    foreach (tbl[i]) begin
      {crit_fault_i, dup_done_i, io_timeout_i, online_i, connected_i} = tbl[i][7:3];
      step(2);
      a = bus_led_o;
      step(4);
      chk("bus_any", {6'h00, tbl[i][1:0]}, {6'h00, a | bus_led_o});
      chk("bus_both", {6'h00, tbl[i][2] ? 2'h0 : tbl[i][1:0]}, {6'h00, a & bus_led_o});
      chk("dev", 8'h02, {6'h00, dev_led_o});
    end
    acc(1'h0, 16'h0096, 8'h08, 8'h00, 8'h01, 1'h0, 1'h0);
    acc(1'h1, 16'h0096, 8'h08, 8'h00, 8'h00, 1'h0, 1'h1);
    acc(1'h0, 16'h0096, 8'h08, 8'h00, 8'h00, 1'h0, 1'h0);
    acc(1'h1, 16'h0096, 8'h08, 8'h00, 8'h00, 1'h0, 1'h0);
    fin(1'h1);
    acc(1'h0, 16'h0096, 8'h08, 8'h00, 8'h03, 1'h0, 1'h0);
    acc(1'h1, 16'h0096, 8'h08, 8'h01, 8'h00, 1'h0, 1'h0);
    acc(1'h1, 16'h0096, 8'h08, 8'h00, 8'h00, 1'h0, 1'h1);
    acc(1'h0, 16'h0096, 8'h08, 8'h00, 8'h00, 1'h0, 1'h0);
    fin(1'h0);
    acc(1'h0, 16'h0096, 8'h08, 8'h00, 8'h01, 1'h0, 1'h0);
    acc(1'h1, 16'h0096, 8'h07, 8'h00, 8'h00, 1'h1, 1'h0);
    acc(1'h0, 16'h0095, 8'h08, 8'h00, 8'h00, 1'h1, 1'h0);
    // an end while idle must not touch the stored outcome
    fin(1'h1);
    acc(1'h0, 16'h0096, 8'h08, 8'h00, 8'h01, 1'h0, 1'h0);
    m.inst_sel = 16'h0002;
    acc(1'h0, 16'h0096, 8'h08, 8'h00, 8'h00, 1'h1, 1'h0);
    end_of_test();
  end
endmodule // tas_teach_leds_test

// ### src/tas_teach_leds.sv
// teach attribute handling and two-colour bus / device status indicators
// Function
// R1 - teach byte lives at class 150, instance 1, attribute 8; set and get
// R2 - writing bit 0 as zero starts end-position calibration
// R3 - master treats bit 1 as read-only, writes upper bits as zero
// R4 - read bit 0 is zero while calibrating, one when finished
// R5 - read bit 1 after finish: zero success, one defective
// R6 - power-up lamp test: green quarter second, red, off, brief light
// R7 - status coding shown only after the lamp test completes
// R8 - bus indicator off until duplicate address check ends; a critical fault still shows steady red
// R9 - bus indicator steady green when online and connected
// R10 - bus indicator flashes green when online without connection
// R11 - bus indicator flashes red while an I/O connection timed out
// R12 - bus indicator steady red on critical fault
// R13 - device indicator steady green in normal operation
// R14 - flashing states toggle at roughly one hertz from a counter
`timescale 1ns/10ps
`include "tas_consts.svh"

module tas_teach_leds
  import tas_pkg::*;
#(
  parameter int unsigned STEP_CYC = `TAS_STEP_MS * `TAS_CLK_KHZ,
  parameter int unsigned FLASH_CYC = `TAS_FLASH_MS * `TAS_CLK_KHZ
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // attribute access from the explicit message layer
  input wire logic req_valid_i,
  input wire tas_req_t req_i,
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_err_o,
  // calibration engine
  output logic teach_start_o,
  input wire logic teach_end_i,
  input wire logic teach_fail_i,
  // network state
  input wire logic dup_done_i,
  input wire logic online_i,
  input wire logic connected_i,
  input wire logic io_timeout_i,
  input wire logic crit_fault_i,
  // indicators
  output tas_led_t bus_led_o,
  output tas_led_t dev_led_o
);

  function automatic logic path_hit(input tas_req_t r);
    return (r.cls == `TAS_CLASS) && (r.inst == `TAS_INST) && (r.attr == `TAS_ATTR);
  endfunction

  // ---------------- teach attribute ----------------
  logic done_reg, done_next;
  logic fail_reg, fail_next;
  logic start_reg, start_next;
  logic rsp_valid_reg, rsp_valid_next;
  logic rsp_err_reg, rsp_err_next;
  logic [7:0] rsp_data_reg, rsp_data_next;
  logic start_req;

  // R1 path decode
  // R2 start on bit 0 low; ignored while a run is in progress
  assign start_req = req_valid_i && req_i.write && path_hit(req_i) &&
                     !req_i.data[`TAS_BIT_CMD] && done_reg;

  always_comb begin
    done_next = done_reg;
    fail_next = fail_reg;
    start_next = start_req;
    rsp_valid_next = req_valid_i;
    rsp_err_next = req_valid_i && !path_hit(req_i);
    rsp_data_next = 8'h00;
    // R5 outcome latched at the end of the run
    if (teach_end_i && !done_reg) begin
      done_next = 1'b1;
      fail_next = teach_fail_i;
    end
    // R4 running shows as bit 0 low; a new start wins over a stale end
    if (start_req) begin
      done_next = 1'b0;
      fail_next = 1'b0;
    end
    // R3 upper bits read as zero, bit 1 never written
    if (req_valid_i && !req_i.write && path_hit(req_i)) begin
      rsp_data_next[`TAS_BIT_DONE] = done_reg;
      rsp_data_next[`TAS_BIT_FAIL] = fail_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_reg <= `TAS_DONE_RST;
      fail_reg <= `TAS_FAIL_RST;
      start_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_err_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
    end else begin
      done_reg <= done_next;
      fail_reg <= fail_next;
      start_reg <= start_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_err_reg <= rsp_err_next;
      rsp_data_reg <= rsp_data_next;
    end
  end

  assign teach_start_o = start_reg;
  assign rsp_valid_o = rsp_valid_reg;
  assign rsp_err_o = rsp_err_reg;
  assign rsp_data_o = rsp_data_reg;

  // ---------------- lamp test and flash timing ----------------
  tas_lamp_t phase_reg, phase_next;
  logic [31:0] step_cnt_reg, step_cnt_next;
  logic [31:0] flash_cnt_reg, flash_cnt_next;
  logic flash_reg, flash_next;

  always_comb begin
    phase_next = phase_reg;
    step_cnt_next = step_cnt_reg;
    // R6 each lamp test step lasts one step period
    if (phase_reg != LT_RUN) begin
      if (step_cnt_reg == STEP_CYC - 32'h1) begin
        step_cnt_next = 32'h0;
        case (phase_reg)
          LT_GREEN: phase_next = LT_RED;
          LT_RED: phase_next = LT_OFF;
          LT_OFF: phase_next = LT_BOTH;
          LT_BOTH: phase_next = LT_RUN;
          default: phase_next = LT_RUN;
        endcase
      end else begin
        step_cnt_next = step_cnt_reg + 32'h1;
      end
    end
    // R14 free-running half period toggle
    flash_next = flash_reg;
    if (flash_cnt_reg == FLASH_CYC - 32'h1) begin
      flash_cnt_next = 32'h0;
      flash_next = !flash_reg;
    end else begin
      flash_cnt_next = flash_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_reg <= LT_GREEN;
      step_cnt_reg <= 32'h0;
      flash_cnt_reg <= 32'h0;
      flash_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      step_cnt_reg <= step_cnt_next;
      flash_cnt_reg <= flash_cnt_next;
      flash_reg <= flash_next;
    end
  end

  // ---------------- indicator coding ----------------
  tas_led_t bus_reg, bus_next;
  tas_led_t dev_reg, dev_next;

  always_comb begin
    bus_next = '0;
    dev_next = '0;
    case (phase_reg)
      // R6 lamp test colours on both indicators
      LT_GREEN: begin
        bus_next.grn = 1'b1;
        dev_next.grn = 1'b1;
      end
      LT_RED: begin
        bus_next.red = 1'b1;
        dev_next.red = 1'b1;
      end
      LT_OFF: bus_next = '0;
      LT_BOTH: begin
        bus_next = '1;
        dev_next = '1;
      end
      // R7 status coding only once the test is over
      LT_RUN: begin
        // R13 device steady green once the lamp test is over
        dev_next.grn = 1'b1;
        // R12 critical fault overrides everything, a duplicate included
        if (crit_fault_i) begin
          bus_next.red = 1'b1;
        // R8 dark until the duplicate address check ends
        end else if (!dup_done_i) begin
          bus_next = '0;
        // R11 timed-out connection
        end else if (io_timeout_i) begin
          bus_next.red = flash_reg;
        // R9 connected
        end else if (online_i && connected_i) begin
          bus_next.grn = 1'b1;
        // R10 online only
        end else if (online_i) begin
          bus_next.grn = flash_reg;
        end
      end
      default: bus_next = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_reg <= '0;
      dev_reg <= '0;
    end else begin
      bus_reg <= bus_next;
      dev_reg <= dev_next;
    end
  end

  assign bus_led_o = bus_reg;
  assign dev_led_o = dev_reg;

  // ---------------- assertions ----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  logic run_ok;
  assign run_ok = (phase_reg == LT_RUN) && !crit_fault_i && dup_done_i && !io_timeout_i;

  sequence s_start_req;
    req_valid_i && req_i.write && path_hit(req_i) && !req_i.data[`TAS_BIT_CMD] && done_reg;
  endsequence
  sequence s_start_seen;
    teach_start_o && !done_reg;
  endsequence

  property p_start;
    s_start_req |=> s_start_seen;
  endproperty
  a_start: assert property (p_start) else $error("teach start missing"); // R2
  property p_path;
    req_valid_i && !path_hit(req_i) |=> rsp_valid_o && rsp_err_o && rsp_data_o == 8'h00;
  endproperty
  a_path: assert property (p_path) else $error("bad path answer"); // R1
  property p_running_read;
    !done_reg && !teach_end_i && req_valid_i && !req_i.write && path_hit(req_i)
      |=> rsp_valid_o && !rsp_data_o[`TAS_BIT_DONE] && rsp_data_o[7:2] == 6'h00;
  endproperty
  a_running_read: assert property (p_running_read) else $error("running not shown"); // R4
  property p_result;
    !done_reg && teach_end_i && !start_req |=> done_reg && fail_reg == $past(teach_fail_i);
  endproperty
  a_result: assert property (p_result) else $error("result not latched"); // R5
  property p_lamp_green;
    phase_reg == LT_GREEN |=> bus_led_o.grn && !bus_led_o.red && dev_led_o.grn;
  endproperty
  a_lamp_green: assert property (p_lamp_green) else $error("lamp test green wrong"); // R6
  property p_lamp_order;
    phase_reg == LT_GREEN && step_cnt_reg == STEP_CYC - 32'h1 |=> phase_reg == LT_RED;
  endproperty
  a_lamp_order: assert property (p_lamp_order) else $error("lamp step order"); // R6
  // both indicators mirror each other until the test ends, so no status leaks
  property p_no_status_early;
    phase_reg != LT_RUN |=> bus_led_o == dev_led_o;
  endproperty
  a_no_status_early: assert property (p_no_status_early) else $error("status too early"); // R7
  property p_dup_dark;
    phase_reg == LT_RUN && !crit_fault_i && !dup_done_i |=> bus_led_o == '0;
  endproperty
  a_dup_dark: assert property (p_dup_dark) else $error("bus lit during check"); // R8
  property p_conn_green;
    run_ok && online_i && connected_i |=> bus_led_o.grn && !bus_led_o.red;
  endproperty
  a_conn_green: assert property (p_conn_green) else $error("no steady green"); // R9
  property p_flash_green;
    run_ok && online_i && !connected_i |=> bus_led_o.grn == $past(flash_reg) && !bus_led_o.red;
  endproperty
  a_flash_green: assert property (p_flash_green) else $error("no green flash"); // R10
  property p_flash_red;
    phase_reg == LT_RUN && !crit_fault_i && dup_done_i && io_timeout_i
      |=> bus_led_o.red == $past(flash_reg) && !bus_led_o.grn;
  endproperty
  a_flash_red: assert property (p_flash_red) else $error("no red flash"); // R11
  property p_crit;
    phase_reg == LT_RUN && crit_fault_i |=> bus_led_o.red && !bus_led_o.grn;
  endproperty
  a_crit: assert property (p_crit) else $error("no steady red"); // R12
  property p_dev;
    phase_reg == LT_RUN |=> dev_led_o.grn && !dev_led_o.red;
  endproperty
  a_dev: assert property (p_dev) else $error("device led wrong"); // R13
  property p_flash_rate;
    flash_cnt_reg != FLASH_CYC - 32'h1 |=> $stable(flash_reg);
  endproperty
  a_flash_rate: assert property (p_flash_rate) else $error("flash toggled early"); // R14
endmodule // tas_teach_leds
